// ---- shared/tpwm_regs.vh ----
// Overview of operation
// - Edge select register holds two-bit trigger edge and event edge fields.
// - Buffer transfer is armed only by a duty compare write, not period alone.
// - Armed transfer copies both compares to buffers at counter clear; compare uses buffers.
// - Duty zero keeps the output low all period.
// - Duty zero with period all ones still raises duty match each period.
// - Duty equal to period plus one keeps output high all period.
// - Period all ones cannot give a full-high waveform.
// - Period is period compare plus one counts; width is duty compare counts.
// - Enabled timer waits for trigger; each trigger clears, restarts and drives output high unless duty is zero.
// - Trigger is selected external edge or soft trigger bit written one.
// - Period match at the clear after counter equals period; duty match at equality.
`ifndef TPWM_REGS_VH
`define TPWM_REGS_VH
`define TPWM_OFF_CTRL 8'h00
`define TPWM_OFF_EDGE 8'h04
`define TPWM_OFF_PERIOD 8'h08
`define TPWM_OFF_DUTY 8'h0C
`define TPWM_OFF_STATUS 8'h10
`define TPWM_OFF_MASK 8'h14
`define TPWM_OFF_COUNT 8'h18
`define TPWM_OFF_PRESC 8'h1C
`define TPWM_CTRL_RUN 0
`define TPWM_CTRL_SOFT 1
`define TPWM_ST_PERIOD 0
`define TPWM_ST_DUTY 1
`define TPWM_ST_TRIG 2
`define TPWM_EDGE_RST 8'h00
`define TPWM_CMP_RST 16'h0000
`define TPWM_CNT_IDLE 16'hFFFF
`define TPWM_PRESC_RST 16'h0000
`define TPWM_SLVERR_UNMAPPED 1'b1
`endif

// ---- core/tpwm_timer.v ----
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tpwm_regs.vh"
module tpwm_timer (
  // APB clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // External trigger and event pins
  input wire trig_in,
  input wire event_in,
  // Outputs
  output reg pwm_out,
  output wire irq
);

  // One-hot counter states
  localparam ST_IDLE = 2'b01;
  localparam ST_COUNT = 2'b10;

  // State and control
  reg [1:0] state;
  reg timer_run;
  reg [7:0] edge_select_ctrl;
  // Compare registers as software wrote them
  reg [15:0] period_compare;
  reg [15:0] duty_compare;
  // Buffered compares; the counter only ever looks at these
  reg [15:0] period_buf;
  reg [15:0] duty_buf;
  // Count clock divider
  reg [15:0] presc;
  reg [15:0] presc_cnt;
  // Counter and the pending buffer transfer
  reg [15:0] count;
  reg xfer_armed;
  // Interrupt status and mask, same layout
  reg [2:0] status;
  reg [2:0] mask;
  // Read data captured in the setup cycle
  reg [31:0] rdata;
  reg rerr;

  // Bit 0 is the trigger pin, bit 1 the event pin
  wire [1:0] pin_raw;
  // Filtered levels and the edges seen on them
  wire [1:0] pin_lvl;
  wire [1:0] pin_rise;
  wire [1:0] pin_fall;
  // Edge picked by each pin's select field
  wire [1:0] pin_edge;

  // APB access qualifiers
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  // One-cycle count clock enable
  // With presc zero the enable is high every cycle
  wire tick = (presc_cnt == presc);
  // Soft trigger is a write pulse; the bit itself is not stored
  wire soft_trig = wr & (paddr == `TPWM_OFF_CTRL) & pwdata[`TPWM_CTRL_SOFT];
  wire ext_trig;
  wire evt_edge;
  wire trigger;
  // Compare hits against the buffered values only
  // Period match needs the tick too, so the count holds between ticks
  wire at_period = (state == ST_COUNT) & (count == period_buf);
  wire clear_now = tick & at_period;
  wire duty_hit = (state == ST_COUNT) & tick & (count == duty_buf);
  // Next count; wraps only from FFFF, in idle or at an all-ones period end, where it is never used
  wire [15:0] count_next = count + 16'h0001;

  // Pins gathered so one loop serves both
  // The event pin only sets a status bit; it never counts
  assign pin_raw = {event_in, trig_in};

  // Per-pin synchroniser, filter and edge decode
  // Both pins share one structure; only the select field differs
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_pin
      // Three stages; only stage two reads stage one
      reg [2:0] sync;
      // Level accepted on the previous cycle
      reg lvl_prev;
      // Two-bit field: 00 none, 01 rising, 10 falling, 11 both
      wire [1:0] sel;

      assign sel = edge_select_ctrl[2 * gi + 1:2 * gi];

      // A change counts only once stages two and three agree,
      // so a one-cycle glitch never becomes an edge
      assign pin_lvl[gi] = (sync[2] == sync[1]) ? sync[1] : lvl_prev;
      assign pin_rise[gi] = pin_lvl[gi] & ~lvl_prev;
      assign pin_fall[gi] = ~pin_lvl[gi] & lvl_prev;

      // Edge select decode; code 00 leaves the pin ignored
      assign pin_edge[gi] = (sel == 2'b01) ? pin_rise[gi] :
        (sel == 2'b10) ? pin_fall[gi] :
        (sel == 2'b11) ? (pin_rise[gi] | pin_fall[gi]) :
        1'b0;

      // Reset to the idle low level so no false edge follows reset
      // Limitation: pin pulses shorter than two pclk cycles are lost
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync <= 3'b000;
          lvl_prev <= 1'b0;
        end else begin
          sync <= {sync[1:0], pin_raw[gi]};
          lvl_prev <= pin_lvl[gi];
        end
      end
    end
  endgenerate

  // Trigger pin on bit 0, event pin on bit 1
  assign ext_trig = pin_edge[0];
  assign evt_edge = pin_edge[1];

  // Trigger only counts while the timer is enabled;
  // a soft trigger written while stopped is dropped, not held
  assign trigger = timer_run & (ext_trig | soft_trig);

  // Count clock enable from prescaler; restarts on a trigger so the first count is whole
  // Divider ratio is presc plus one; held at zero in idle
  // Trade-off: a retrigger discards the partial count-clock cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_cnt <= 16'h0000;
    end else if (trigger || tick || state == ST_IDLE) begin
      presc_cnt <= 16'h0000;
    end else begin
      presc_cnt <= presc_cnt + 16'h0001;
    end
  end

  // Register writes; APB writes take effect at the access edge
  // Compares reset to zero, so an early trigger gives a 0% output
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_run <= 1'b0;
      edge_select_ctrl <= `TPWM_EDGE_RST;
      period_compare <= `TPWM_CMP_RST;
      duty_compare <= `TPWM_CMP_RST;
      mask <= 3'b000;
      presc <= `TPWM_PRESC_RST;
    end else if (wr) begin
      case (paddr)
        // Run bit only; the soft trigger bit is a pulse, not stored
        `TPWM_OFF_CTRL: timer_run <= pwdata[`TPWM_CTRL_RUN];
        // Upper edge bits are reserved and read as zero
        `TPWM_OFF_EDGE: edge_select_ctrl <= {4'h0, pwdata[3:0]};
        // Compares; arming is handled in its own process
        `TPWM_OFF_PERIOD: period_compare <= pwdata[15:0];
        `TPWM_OFF_DUTY: duty_compare <= pwdata[15:0];
        // Mask and divider take effect on the next cycle
        `TPWM_OFF_MASK: mask <= pwdata[2:0];
        `TPWM_OFF_PRESC: presc <= pwdata[15:0];
        // Read-only and unmapped addresses ignore writes
        default: timer_run <= timer_run;
      endcase
    end
  end

  // Transfer arming: only a duty write arms; the clear that copies wins over nothing else
  // A duty write landing on a clear edge stays armed for the next clear
  // A retrigger also consumes the arm, since it reloads the buffers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer_armed <= 1'b0;
    end else if (wr && paddr == `TPWM_OFF_DUTY) begin
      xfer_armed <= 1'b1;
    end else if (clear_now || trigger) begin
      xfer_armed <= 1'b0;
    end
  end

  // Counter state machine; buffers load at every clear while armed
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      count <= `TPWM_CNT_IDLE;
      period_buf <= `TPWM_CMP_RST;
      duty_buf <= `TPWM_CMP_RST;
      pwm_out <= 1'b0;
    end else if (!timer_run) begin
      // Stopping parks the counter at FFFF; buffers keep their values
      state <= ST_IDLE;
      count <= `TPWM_CNT_IDLE;
      pwm_out <= 1'b0;
    end else begin
      case (state)
        // First trigger always loads both buffers, armed or not
        ST_IDLE: begin
          if (trigger) begin
            state <= ST_COUNT;
            count <= 16'h0000;
            period_buf <= period_compare;
            duty_buf <= duty_compare;
            pwm_out <= (duty_compare != 16'h0000);
          end
        end
        // Running: a retrigger beats a clear, a clear beats a step
        ST_COUNT: begin
          if (trigger) begin
            // Retrigger restarts the period; output set high unless the duty taken is zero
            count <= 16'h0000;
            pwm_out <= (xfer_armed ? duty_compare : duty_buf) != 16'h0000;
            // An unarmed retrigger keeps the running buffers
            if (xfer_armed) begin
              period_buf <= period_compare;
              duty_buf <= duty_compare;
            end
          end else if (clear_now) begin
            // Period end: clear the count and take any armed transfer
            count <= 16'h0000;
            if (xfer_armed) begin
              period_buf <= period_compare;
              duty_buf <= duty_compare;
              pwm_out <= (duty_compare != 16'h0000);
            end else begin
              pwm_out <= (duty_buf != 16'h0000);
            end
          end else if (tick) begin
            // Plain count step on the count clock enable
            count <= count_next;
            // Duty of period+1 never matches before clear, so output stays high
            if (count_next == duty_buf) begin
              pwm_out <= 1'b0;
            end
          end
        end
        // Illegal code falls back to idle
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Write-one-to-clear bits for this cycle
  // Only a written one clears; a written zero leaves a bit alone
  wire [2:0] st_clr = (wr && paddr == `TPWM_OFF_STATUS) ? pwdata[2:0] : 3'b000;
  // Events of this cycle, in status register layout
  // Bit 2 reports the event pin edge and has no other effect
  wire [2:0] st_set = {evt_edge, duty_hit, clear_now};

  // Sticky status; a hardware set beats a same-cycle write-one clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= 3'b000;
    end else begin
      status <= (status & ~st_clr) | st_set;
    end
  end

  // Level interrupt, high while any unmasked status bit is set
  assign irq = |(status & mask);

  // Read mux; data is registered at the setup cycle so it is steady in access
  // Unmapped or unaligned addresses answer with an error and zero
  // Error flag is refreshed at every setup, so it never goes stale
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= 32'h00000000;
      rerr <= 1'b0;
    end else if (psel && !penable) begin
      rerr <= 1'b0;
      case (paddr)
        // Soft trigger reads as zero
        `TPWM_OFF_CTRL: rdata <= {31'h0, timer_run};
        `TPWM_OFF_EDGE: rdata <= {24'h000000, edge_select_ctrl};
        // Compares read back as written, not as buffered
        `TPWM_OFF_PERIOD: rdata <= {16'h0000, period_compare};
        `TPWM_OFF_DUTY: rdata <= {16'h0000, duty_compare};
        `TPWM_OFF_STATUS: rdata <= {29'h0, status};
        `TPWM_OFF_MASK: rdata <= {29'h0, mask};
        // Count reads FFFF while idle
        `TPWM_OFF_COUNT: rdata <= {16'h0000, count};
        `TPWM_OFF_PRESC: rdata <= {16'h0000, presc};
        default: begin
          rdata <= 32'h00000000;
          rerr <= `TPWM_SLVERR_UNMAPPED;
        end
      endcase
    end
  end

  // No wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  // Read data and error show only in the access phase,
  // so a shared read bus sees zero from an idle slave
  assign prdata = acc ? rdata : 32'h00000000;
  assign pslverr = acc & rerr;

endmodule // tpwm_timer
`default_nettype wire

// ---- bench/tpwm_pin_src.sv ----
`timescale 1ns/1ps
`default_nettype none
module tpwm_pin_src (
  // Bench side
  input wire logic pclk,
  input wire logic fire,
  // Pins toward the timer
  output logic trig_in,
  output logic event_in
);
  logic [3:0] hold = 4'h0;
  // Pulse held 8 cycles so the input filter settles
  always @(posedge pclk) begin
    hold <= fire ? 4'h8 : hold - {3'h0, hold != 4'h0};
  end
  // Rising edge on both pins at once
  assign trig_in = hold != 4'h0;
  assign event_in = trig_in;
endmodule // tpwm_pin_src
`default_nettype wire

// ---- bench/tpwm_timer_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module tpwm_chk (
  // APB side
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins
  input wire logic pwm_out,
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [15:0] duty_w;
  // Last duty written; buffer follows it after each clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) duty_w <= 16'h0000;
    else if (psel && penable && pwrite && paddr == 8'h0C) duty_w <= pwdata[15:0];
  end
  sequence acc;
    psel && penable;
  endsequence
  sequence wr_to(logic [7:0] a);
    acc ##0 pwrite && paddr == a;
  endsequence
  rdy_always_a:
    assert property (pready) else $error("pready low");
  err_access_a:
    assert property (pslverr |-> psel && penable) else $error("pslverr outside access");
  rdata_idle_a:
    assert property (!(psel && penable) |-> prdata == 32'h0) else $error("prdata not zero");
  unmapped_err_a:
    assert property (acc ##0 paddr > 8'h1C |-> pslverr) else $error("no error on unmapped");
  mapped_ok_a:
    assert property (acc ##0 paddr <= 8'h1C && paddr[1:0] == 2'h0 |-> !pslverr) else $error("error on mapped");
  mask_quiet_a:
    assert property (wr_to(8'h14) ##0 pwdata[2:0] == 3'h0 |=> !irq) else $error("irq while masked");
  stop_low_a:
    assert property (wr_to(8'h00) ##0 !pwdata[0] |-> ##2 !pwm_out) else $error("pwm high when stopped");
  soft_trig_a:
    assert property (wr_to(8'h00) ##0 pwdata[1:0] == 2'h3 && duty_w != 16'h0 |-> ##[1:2] pwm_out)
      else $error("soft trigger gave no pulse");
endmodule // tpwm_chk
`default_nettype wire

// ---- bench/tb_triggered_pwm_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_triggered_pwm_timer;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fire = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, trig_in, event_in, pwm_out, irq, se;
  int err_count = 0, total_checks = 0, cyc = 0;
  int dv[3] = '{0, 10, 3};
  always #2.5 pclk = ~pclk;
  tpwm_timer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trig_in(trig_in), .event_in(event_in), .pwm_out(pwm_out), .irq(irq));
  tpwm_pin_src src_u (.pclk(pclk), .fire(fire), .trig_in(trig_in), .event_in(event_in));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // One transfer, then an idle cycle so psel is never set twice at one edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    se = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd & m, e);
  endtask
  // High cycles over a window of whole periods
  task automatic duty_cnt(input int n, input int e);
    int hi;
    hi = 0;
    repeat (n) begin
      @(posedge pclk);
      hi += pwm_out;
    end
    check(hi, e);
  endtask
  // One pin pulse, then time for both of its edges to pass the filter
  task automatic pulse_pin;
    fire <= 1;
    @(posedge pclk);
    fire <= 0;
    repeat (16) @(posedge pclk);
  endtask
  // Hang guard, far above the few hundred cycles needed
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      close_out;
    end
  end
  initial begin
    repeat (2) @(posedge pclk);
    check(pwm_out, 1'b0);
    presetn <= 1;
    rc(8'h04, 32'hFFFF_FFFF, 32'h0);
    rc(8'h18, 32'hFFFF, 32'hFFFF);
    wr(8'h04, 32'hFFFF_FFFF);
    rc(8'h04, 32'hFFFF_FFFF, 32'hF);
    rc(8'h40, 32'hFFFF_FFFF, 32'h0);
    check(se, 1'b1);
    wr(8'h04, 32'h5);
    wr(8'h14, 32'h0);
    // 0%, 100% and plain duty at period 10
    for (int i = 0; i < 3; i++) begin
      wr(8'h00, 32'h0);
      wr(8'h08, 32'h9);
      wr(8'h0C, dv[i]);
      wr(8'h00, 32'h1);
      wr(8'h00, 32'h3);
      repeat (4) @(posedge pclk);
      duty_cnt(30, 3 * dv[i]);
    end
    wr(8'h08, 32'h4);
    repeat (12) @(posedge pclk);
    duty_cnt(30, 9);
    wr(8'h0C, 32'h3);
    repeat (12) @(posedge pclk);
    duty_cnt(15, 9);
    wr(8'h0C, 32'h4);
    repeat (12) @(posedge pclk);
    duty_cnt(15, 12);
    wr(8'h14, 32'h3);
    check(irq, 1'b1);
    rc(8'h10, 32'h3, 32'h3);
    wr(8'h00, 32'h0);
    wr(8'h10, 32'h7);
    rc(8'h10, 32'h7, 32'h0);
    check(irq, 1'b0);
    wr(8'h14, 32'h4);
    wr(8'h00, 32'h1);
    rc(8'h18, 32'hFFFF, 32'hFFFF);
    pulse_pin;
    apb(1'b0, 8'h18, 32'h0);
    check(rd[15:0] != 16'hFFFF, 1'b1);
    check(irq, 1'b1);
    // Edge code 00 ignores the pin, code 10 on the event field takes its fall
    wr(8'h04, 32'h0);
    wr(8'h10, 32'h7);
    pulse_pin;
    rc(8'h10, 32'h4, 32'h0);
    wr(8'h04, 32'h8);
    pulse_pin;
    rc(8'h10, 32'h4, 32'h4);
    close_out;
  end
endmodule // tb_triggered_pwm_timer
bind tpwm_timer tpwm_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pwm_out(pwm_out), .irq(irq));
`default_nettype wire
